// File: epc_loader_chk.sv
// Assertions on the ports of the configuration field loader
`timescale 1ns/1ps
`default_nettype none
module epc_loader_chk #(
  parameter logic [7:0] WORD_P3 = 8'h46
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wordValid,
  input wire logic [7:0] wordAddr,
  input wire logic [15:0] wordData,
  input wire logic cfgReq,
  input wire logic cfgReady,
  input wire logic cfgAck,
  input wire logic [2:0] complianceToDetect,
  input wire logic [2:0][1:0] dataChangeCountSelect,
  input wire logic [1:0][4:0] phyParamTwo,
  input wire logic [1:0][6:0] phyParamThree,
  input wire logic [1:0] deemphasisSelect,
  input wire logic [2:0] noSoftReset,
  input wire logic [2:0][2:0] auxCurrent,
  input wire logic [2:0] d1Support,
  input wire logic [2:0] d2Support,
  input wire logic [2:0][1:0] pmeSupport,
  input wire logic [2:0][7:0] pmData
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // A memory word offered while loading is still going on
  sequence take(logic [7:0] a);
    wordValid && wordAddr == a && !cfgReady;
  endsequence
  // Access handshake and load ordering
  AST_ACK_ONE: assert property (cfgReq && cfgReady |=> cfgAck)
    else $error("taken request not answered next cycle");
  AST_ACK_CAUSE: assert property (cfgAck |-> $past(cfgReq && cfgReady))
    else $error("answer without a taken request");
  AST_WORD_LATE: assert property (wordValid |-> !cfgReady)
    else $error("ready before the memory finished");
  // Field copies from each memory word
  AST_P3_WORD: assert property (take(WORD_P3) |=>
    {dataChangeCountSelect[0], complianceToDetect[0]} == $past(wordData[15:13]))
    else $error("port 3 word not copied");
  AST_P4_WORD: assert property (take(8'h48) |=>
    {dataChangeCountSelect[1], complianceToDetect[1], deemphasisSelect[0],
    phyParamThree[0], phyParamTwo[0]} == $past(wordData))
    else $error("port 4 word not copied");
  AST_P5_WORD: assert property (take(8'h4A) |=>
    {dataChangeCountSelect[2], complianceToDetect[2], deemphasisSelect[1],
    phyParamThree[1], phyParamTwo[1]} == $past(wordData))
    else $error("port 5 word not copied");
  AST_P0_CAP: assert property (take(8'h50) |=>
    {pmeSupport[0], d2Support[0], d1Support[0], auxCurrent[0], noSoftReset[0]}
    == $past(wordData[7:0])) else $error("port 0 capability not copied");
  AST_P0_DATA: assert property (take(8'h51) |=>
    pmData[0] == $past(wordData[15:8])) else $error("port 0 data not copied");
  AST_P1_CAP: assert property (take(8'h52) |=>
    {pmeSupport[1], d2Support[1], d1Support[1], auxCurrent[1], noSoftReset[1]}
    == $past(wordData[7:0])) else $error("port 1 capability not copied");
  AST_P1_DATA: assert property (take(8'h53) |=>
    pmData[1] == $past(wordData[15:8])) else $error("port 1 data not copied");
  AST_P2_CAP: assert property (take(8'h54) |=>
    {pmeSupport[2], d2Support[2], d1Support[2], auxCurrent[2], noSoftReset[2]}
    == $past(wordData[7:0])) else $error("port 2 capability not copied");
  AST_RO_HOLD: assert property (
    cfgReady && $past(cfgReady) |->
    $stable(pmData) && $stable(d1Support) && $stable(d2Support))
    else $error("read-only field changed after loading");
endmodule
bind epc_port_config_loader epc_loader_chk #(.WORD_P3(WORD_P3)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .wordValid(wordValid),
  .wordAddr(wordAddr), .wordData(wordData), .cfgReq(cfgReq),
  .cfgReady(cfgReady), .cfgAck(cfgAck),
  .complianceToDetect(complianceToDetect),
  .dataChangeCountSelect(dataChangeCountSelect), .phyParamTwo(phyParamTwo),
  .phyParamThree(phyParamThree), .deemphasisSelect(deemphasisSelect),
  .noSoftReset(noSoftReset), .auxCurrent(auxCurrent), .d1Support(d1Support),
  .d2Support(d2Support), .pmeSupport(pmeSupport), .pmData(pmData));
`default_nettype wire

// File: epc_mem_model.sv
// Serial configuration memory reader model streaming its stored words
`timescale 1ns/1ps
`default_nettype none
module epc_mem_model #(
  parameter logic [7:0] WORD_P3 = 8'h46,
  parameter logic [7:0][15:0] MEM = '0
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic present,
  input wire logic flip,
  input wire logic [3:0] gap,
  output logic memPresent,
  output logic wordValid,
  output logic [7:0] wordAddr,
  output logic [15:0] wordData,
  output logic loadDone,
  output logic busy
);
  logic [7:0][7:0] addrs;
  // Word addresses in streaming order
  assign addrs = {8'h54, 8'h53, 8'h52, 8'h51, 8'h50, 8'h4A, 8'h48, WORD_P3};
  assign memPresent = present;
  // When present, streams every word after reset, stalling gap cycles after each word
  initial begin
    wordValid = 1'b0;
    loadDone = 1'b0;
    busy = 1'b0;
    wordAddr = 8'h00;
    wordData = 16'h0000;
    forever begin
      @(posedge rstn);
      if (present) begin
        busy = 1'b1;
        repeat (4) @(negedge core_clk);
        for (int i = 0; i < 8; i++) begin
          wordValid = 1'b1;
          wordAddr = addrs[i];
          wordData = flip ? ~MEM[i] : MEM[i];
          @(negedge core_clk);
          if (gap != 4'h0) begin
            wordValid = 1'b0;
            wordAddr = ~wordAddr;  // Released lines show no stale value
            wordData = ~wordData;
            repeat (gap) @(negedge core_clk);
          end
        end
        wordValid = 1'b0;
        wordAddr = ~wordAddr;
        wordData = ~wordData;
        loadDone = 1'b1;
        busy = 1'b0;
        @(negedge core_clk);
        loadDone = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: epc_pkg.sv
// Constants for the configuration memory port field loader
package epc_pkg;

  // Configuration memory word addresses
  localparam logic [7:0] WORD_P4 = 8'h48;
  localparam logic [7:0] WORD_P5 = 8'h4A;
  localparam logic [7:0] WORD_P0_CAP = 8'h50;
  localparam logic [7:0] WORD_P0_DATA = 8'h51;
  localparam logic [7:0] WORD_P1_CAP = 8'h52;
  localparam logic [7:0] WORD_P1_DATA = 8'h53;
  localparam logic [7:0] WORD_P2_CAP = 8'h54;

  // Configuration space offsets
  localparam logic [7:0] OFS_PM_CAP = 8'h40;
  localparam logic [7:0] OFS_POWER_MGMT_CONTROL_DATA = 8'h44;
  localparam logic [7:0] OFS_COMPLIANCE = 8'h78;
  localparam logic [7:0] OFS_PHY_TWO = 8'h7C;
  localparam logic [7:0] OFS_TL_CONTROL = 8'h8C;
  localparam logic [7:0] OFS_PHY_THREE = 8'h90;
  localparam logic [7:0] OFS_DEEMPH = 8'hF0;

  // Source bit positions inside a memory word (ports 3 to 5)
  localparam int SRC_PHY2_LSB = 0;
  localparam int SRC_PHY3_LSB = 5;
  localparam int SRC_DEEMPH = 12;
  localparam int SRC_COMPLIANCE = 13;
  localparam int SRC_DCCS_LSB = 14;

  // Source bit positions inside a memory word (ports 0 to 2)
  localparam int SRC_NSR = 0;
  localparam int SRC_AUX_LSB = 1;
  localparam int SRC_D1 = 4;
  localparam int SRC_D2 = 5;
  localparam int SRC_PME_LSB = 6;
  localparam int SRC_PMDATA_LSB = 8;

  // Destination bit positions inside configuration dwords
  localparam int DST_NSR = 3;
  localparam int DST_PMDATA_LSB = 24;
  localparam int DST_AUX_LSB = 22;
  localparam int DST_D1 = 25;
  localparam int DST_D2 = 26;
  localparam int DST_PME_LSB = 28;
  localparam int DST_COMPLIANCE = 11;
  localparam int DST_PHY2_LSB = 8;
  localparam int DST_DCCS_LSB = 8;
  localparam int DST_PHY3_LSB = 0;
  localparam int DST_DEEMPH = 6;

  // Field widths
  localparam int W_PHY2 = 5;
  localparam int W_PHY3 = 7;
  localparam int W_DCCS = 2;
  localparam int W_AUX = 3;
  localparam int W_PME = 2;
  localparam int W_PMDATA = 8;

  // Port numbering
  localparam logic [2:0] PORT_FIRST_DOWN = 3'h3;
  localparam int NUM_DOWN = 3;
  localparam int NUM_PM = 3;

  // Loader states
  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_READY = 2'b10
  } epc_state_t;

endpackage

// File: epc_pm_port.sv
// Power management fields of one upstream-side port, filled from memory
`timescale 1ns/1ps
`default_nettype none
module epc_pm_port #(
  parameter logic [7:0] CAP_WORD = 8'h50,
  parameter logic [7:0] DATA_WORD = 8'h51,
  parameter bit HAS_DATA = 1'b1,
  parameter logic [15:0] CAP_RESET = 16'h0000,
  parameter logic [7:0] DATA_RESET = 8'h00
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wordTake,
  input wire logic [7:0] wordAddr,
  input wire logic [15:0] wordData,
  output logic noSoftReset,
  output logic [epc_pkg::W_AUX-1:0] auxCurrent,
  output logic d1Support,
  output logic d2Support,
  output logic [epc_pkg::W_PME-1:0] pmeSupport,
  output logic [epc_pkg::W_PMDATA-1:0] pmData
);

  // Capability word: reset value then memory copy
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      noSoftReset <= CAP_RESET[epc_pkg::SRC_NSR];
      auxCurrent <= CAP_RESET[epc_pkg::SRC_AUX_LSB +: epc_pkg::W_AUX];
      d1Support <= CAP_RESET[epc_pkg::SRC_D1];
      d2Support <= CAP_RESET[epc_pkg::SRC_D2];
      pmeSupport <= CAP_RESET[epc_pkg::SRC_PME_LSB +: epc_pkg::W_PME];
    end else if (wordTake && wordAddr == CAP_WORD) begin
      noSoftReset <= wordData[epc_pkg::SRC_NSR]; // RQ9
      auxCurrent <= wordData[epc_pkg::SRC_AUX_LSB +: epc_pkg::W_AUX]; // RQ10
      d1Support <= wordData[epc_pkg::SRC_D1]; // RQ11
      d2Support <= wordData[epc_pkg::SRC_D2]; // RQ12
      pmeSupport <= wordData[epc_pkg::SRC_PME_LSB +: epc_pkg::W_PME]; // RQ13
    end
  end

  // Data byte word, only on ports that have one
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pmData <= DATA_RESET;
    end else if (HAS_DATA && wordTake && wordAddr == DATA_WORD) begin
      pmData <= wordData[epc_pkg::SRC_PMDATA_LSB +: epc_pkg::W_PMDATA]; // RQ14
    end
  end

endmodule
`default_nettype wire

// File: epc_port_config_loader.sv
// Loads per-port configuration fields from memory words, serves cfg access
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RQ1 - Word 48h bit 12 sets port 4 de-emphasis select, F0h bit 6.
// RQ2 - Word 4Ah bit 12 sets port 5 de-emphasis select, F0h bit 6.
// RQ3 - Word 48h bit 13 sets port 4 phy_compliance_control, 78h bit 11.
// RQ4 - Word 4Ah bit 13 sets port 5 phy_compliance_control, 78h bit 11.
// RQ5 - Port 3 word bit 13 sets port 3 phy_compliance_control, 78h bit 11.
// RQ6 - Ports 3 to 5: word bits 15:14 into 8Ch bits 9:8.
// RQ7 - Ports 4 and 5: word bits 4:0 into 7Ch bits 12:8.
// RQ8 - Ports 4 and 5: word bits 11:5 into 90h bits 6:0.
// RQ9 - Word 50h bit 0 sets port 0 No_Soft_Reset, 44h bit 3.
// RQ10 - Ports 0 to 2: word bits 3:1 into 40h bits 24:22.
// RQ11 - Word bit 4 loads read-only D1 support, 40h bit 25.
// RQ12 - Word bit 5 loads read-only D2 support, 40h bit 26.
// RQ13 - Word bits 7:6 into PME support field, 40h bits 29:28.
// RQ14 - Word 51h bits 15:8 into read-only port 0 data byte.
// RQ15 - Port 1 takes capability from 52h and data byte from 53h.
// RQ16 - Port 2 takes capability fields from word 54h.
// RQ17 - All loading ends before software accesses; unmapped fields keep reset.
// RQ18 - Without valid memory every mapped field keeps its reset value.
module epc_port_config_loader #(
  parameter logic [7:0] WORD_P3 = 8'h46,
  parameter logic [15:0] DOWN_RESET = 16'h0000,
  parameter logic [15:0] PM_CAP_RESET = 16'h0000,
  parameter logic [7:0] POWER_MGMT_CONTROL_DATA_RESET = 8'h00
) (
  input wire logic core_clk,
  input wire logic rstn,
  // Word stream from the serial memory reader
  input wire logic memPresent,
  input wire logic wordValid,
  input wire logic [7:0] wordAddr,
  input wire logic [15:0] wordData,
  input wire logic loadDone,
  // Configuration access port
  input wire logic cfgReq,
  input wire logic cfgWrite,
  input wire logic [2:0] cfgPort,
  input wire logic [7:0] cfgOffset,
  input wire logic [31:0] cfgWdata,
  output logic cfgReady,
  output logic cfgAck,
  output logic [31:0] cfgRdata,
  // Field values to the switch core
  output logic [epc_pkg::NUM_DOWN-1:0] complianceToDetect,
  output logic [epc_pkg::NUM_DOWN-1:0][epc_pkg::W_DCCS-1:0]
    dataChangeCountSelect,
  output logic [1:0][epc_pkg::W_PHY2-1:0] phyParamTwo,
  output logic [1:0][epc_pkg::W_PHY3-1:0] phyParamThree,
  output logic [1:0] deemphasisSelect,
  output logic [epc_pkg::NUM_PM-1:0] noSoftReset,
  output logic [epc_pkg::NUM_PM-1:0][epc_pkg::W_AUX-1:0] auxCurrent,
  output logic [epc_pkg::NUM_PM-1:0] d1Support,
  output logic [epc_pkg::NUM_PM-1:0] d2Support,
  output logic [epc_pkg::NUM_PM-1:0][epc_pkg::W_PME-1:0] pmeSupport,
  output logic [epc_pkg::NUM_PM-1:0][epc_pkg::W_PMDATA-1:0] pmData
);

  // Port 3 word must not collide with any documented word
  if (WORD_P3 == epc_pkg::WORD_P4 || WORD_P3 == epc_pkg::WORD_P5 ||
      (WORD_P3 >= epc_pkg::WORD_P0_CAP && WORD_P3 <= epc_pkg::WORD_P2_CAP))
  begin : gBadWord
    $error("epc_port_config_loader: WORD_P3 overlaps another word");
  end

  epc_pkg::epc_state_t state;
  epc_pkg::epc_state_t next_state;
  logic presentMeta;
  logic presentSync;
  logic settleMeta;
  logic syncSettled;
  logic wordTake;
  logic cfgTake;
  logic [31:0] next_rdata;
  logic [epc_pkg::NUM_PM-1:0][epc_pkg::W_PMDATA-1:0] pmDataInt;

  // Word address of each downstream port, index 0 is port 3
  function automatic logic [7:0] downWord(input int idx);
    case (idx)
      0: downWord = WORD_P3;
      1: downWord = epc_pkg::WORD_P4;
      default: downWord = epc_pkg::WORD_P5;
    endcase
  endfunction

  // Port to downstream index, all ones when not a downstream port
  function automatic logic [1:0] downIndex(input logic [2:0] port);
    logic [2:0] rel;
    rel = port - epc_pkg::PORT_FIRST_DOWN;
    if (port >= epc_pkg::PORT_FIRST_DOWN && rel < 3'(epc_pkg::NUM_DOWN)) begin
      downIndex = rel[1:0];
    end else begin
      downIndex = 2'h3;
    end
  endfunction

  // Presence synchroniser; its output is trusted only once it has filled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      presentMeta <= 1'b0;
      presentSync <= 1'b0;
      settleMeta <= 1'b0;
      syncSettled <= 1'b0;
    end else begin
      presentMeta <= memPresent;
      presentSync <= presentMeta;
      settleMeta <= 1'b1;
      syncSettled <= settleMeta;
    end
  end

  // Words apply only while loading from a present memory
  assign wordTake = (state == epc_pkg::ST_LOAD) && presentSync &&
    wordValid; // RQ18
  // Software requests are taken only once loading has finished
  assign cfgTake = (state == epc_pkg::ST_READY) && cfgReq; // RQ17

  // Loader sequence
  always_comb begin
    next_state = state;
    unique case (state)
      epc_pkg::ST_LOAD: begin
        if (loadDone || (syncSettled && !presentSync)) begin
          next_state = epc_pkg::ST_READY; // RQ18
        end
      end
      epc_pkg::ST_READY: begin
        next_state = epc_pkg::ST_READY;
      end
      default: begin
        next_state = epc_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= epc_pkg::ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // Ready flag goes high with the ready state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfgReady <= 1'b0;
    end else begin
      cfgReady <= (next_state == epc_pkg::ST_READY); // RQ17
    end
  end

  // Downstream port fields, loaded from memory then software writable
  for (genvar i = 0; i < epc_pkg::NUM_DOWN; i++) begin : gDown
    logic hit;
    logic isWrite;
    assign hit = wordTake && (wordAddr == downWord(i));
    assign isWrite = cfgTake && cfgWrite && (downIndex(cfgPort) == 2'(i));

    // Phy_compliance_control
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        complianceToDetect[i] <= DOWN_RESET[epc_pkg::SRC_COMPLIANCE];
      end else if (hit) begin
        complianceToDetect[i] <=
          wordData[epc_pkg::SRC_COMPLIANCE]; // RQ3 RQ4 RQ5
      end else if (isWrite && cfgOffset == epc_pkg::OFS_COMPLIANCE) begin
        complianceToDetect[i] <= cfgWdata[epc_pkg::DST_COMPLIANCE];
      end
    end

    // Data change count select
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        dataChangeCountSelect[i] <=
          DOWN_RESET[epc_pkg::SRC_DCCS_LSB +: epc_pkg::W_DCCS];
      end else if (hit) begin
        dataChangeCountSelect[i] <=
          wordData[epc_pkg::SRC_DCCS_LSB +: epc_pkg::W_DCCS]; // RQ6
      end else if (isWrite && cfgOffset == epc_pkg::OFS_TL_CONTROL) begin
        dataChangeCountSelect[i] <=
          cfgWdata[epc_pkg::DST_DCCS_LSB +: epc_pkg::W_DCCS];
      end
    end

    // PHY parameters and de-emphasis exist on ports 4 and 5 only
    if (i > 0) begin : gPhy
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          phyParamTwo[i-1] <=
            DOWN_RESET[epc_pkg::SRC_PHY2_LSB +: epc_pkg::W_PHY2];
        end else if (hit) begin
          phyParamTwo[i-1] <=
            wordData[epc_pkg::SRC_PHY2_LSB +: epc_pkg::W_PHY2]; // RQ7
        end else if (isWrite && cfgOffset == epc_pkg::OFS_PHY_TWO) begin
          phyParamTwo[i-1] <=
            cfgWdata[epc_pkg::DST_PHY2_LSB +: epc_pkg::W_PHY2];
        end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          phyParamThree[i-1] <=
            DOWN_RESET[epc_pkg::SRC_PHY3_LSB +: epc_pkg::W_PHY3];
        end else if (hit) begin
          phyParamThree[i-1] <=
            wordData[epc_pkg::SRC_PHY3_LSB +: epc_pkg::W_PHY3]; // RQ8
        end else if (isWrite && cfgOffset == epc_pkg::OFS_PHY_THREE) begin
          phyParamThree[i-1] <=
            cfgWdata[epc_pkg::DST_PHY3_LSB +: epc_pkg::W_PHY3];
        end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          deemphasisSelect[i-1] <= DOWN_RESET[epc_pkg::SRC_DEEMPH];
        end else if (hit) begin
          deemphasisSelect[i-1] <= wordData[epc_pkg::SRC_DEEMPH]; // RQ1 RQ2
        end else if (isWrite && cfgOffset == epc_pkg::OFS_DEEMPH) begin
          deemphasisSelect[i-1] <= cfgWdata[epc_pkg::DST_DEEMPH];
        end
      end
    end
  end

  // Power management fields of ports 0 to 2, read-only to software
  epc_pm_port #(
    .CAP_WORD(epc_pkg::WORD_P0_CAP),
    .DATA_WORD(epc_pkg::WORD_P0_DATA),
    .HAS_DATA(1'b1),
    .CAP_RESET(PM_CAP_RESET),
    .DATA_RESET(POWER_MGMT_CONTROL_DATA_RESET)
  ) uPm0 (
    .core_clk(core_clk),
    .rstn(rstn),
    .wordTake(wordTake),
    .wordAddr(wordAddr),
    .wordData(wordData),
    .noSoftReset(noSoftReset[0]),
    .auxCurrent(auxCurrent[0]),
    .d1Support(d1Support[0]),
    .d2Support(d2Support[0]),
    .pmeSupport(pmeSupport[0]),
    .pmData(pmDataInt[0])
  );

  // Port 1 uses its own capability and data words
  epc_pm_port #(
    .CAP_WORD(epc_pkg::WORD_P1_CAP),
    .DATA_WORD(epc_pkg::WORD_P1_DATA),
    .HAS_DATA(1'b1),
    .CAP_RESET(PM_CAP_RESET),
    .DATA_RESET(POWER_MGMT_CONTROL_DATA_RESET)
  ) uPm1 ( // RQ15
    .core_clk(core_clk),
    .rstn(rstn),
    .wordTake(wordTake),
    .wordAddr(wordAddr),
    .wordData(wordData),
    .noSoftReset(noSoftReset[1]),
    .auxCurrent(auxCurrent[1]),
    .d1Support(d1Support[1]),
    .d2Support(d2Support[1]),
    .pmeSupport(pmeSupport[1]),
    .pmData(pmDataInt[1])
  );

  // Port 2 has a capability word only; its data byte keeps reset value
  epc_pm_port #(
    .CAP_WORD(epc_pkg::WORD_P2_CAP),
    .DATA_WORD(epc_pkg::WORD_P2_CAP),
    .HAS_DATA(1'b0),
    .CAP_RESET(PM_CAP_RESET),
    .DATA_RESET(POWER_MGMT_CONTROL_DATA_RESET)
  ) uPm2 ( // RQ16
    .core_clk(core_clk),
    .rstn(rstn),
    .wordTake(wordTake),
    .wordAddr(wordAddr),
    .wordData(wordData),
    .noSoftReset(noSoftReset[2]),
    .auxCurrent(auxCurrent[2]),
    .d1Support(d1Support[2]),
    .d2Support(d2Support[2]),
    .pmeSupport(pmeSupport[2]),
    .pmData(pmDataInt[2])
  );

  assign pmData = pmDataInt;

  // Read data assembly; unmapped bits and offsets read as zero
  always_comb begin
    logic [1:0] di;
    logic [1:0] pi;
    di = downIndex(cfgPort);
    pi = cfgPort[1:0];
    next_rdata = 32'h0000_0000;
    if (cfgPort < 3'(epc_pkg::NUM_PM)) begin
      if (cfgOffset == epc_pkg::OFS_PM_CAP) begin
        next_rdata[epc_pkg::DST_AUX_LSB +: epc_pkg::W_AUX] = auxCurrent[pi];
        next_rdata[epc_pkg::DST_D1] = d1Support[pi]; // RQ11
        next_rdata[epc_pkg::DST_D2] = d2Support[pi]; // RQ12
        next_rdata[epc_pkg::DST_PME_LSB +: epc_pkg::W_PME] = pmeSupport[pi];
      end else if (cfgOffset == epc_pkg::OFS_POWER_MGMT_CONTROL_DATA) begin
        next_rdata[epc_pkg::DST_NSR] = noSoftReset[pi];
        next_rdata[epc_pkg::DST_PMDATA_LSB +: epc_pkg::W_PMDATA] =
          pmDataInt[pi]; // RQ14
      end
    end else if (di != 2'h3) begin
      unique case (cfgOffset)
        epc_pkg::OFS_COMPLIANCE: begin
          next_rdata[epc_pkg::DST_COMPLIANCE] = complianceToDetect[di];
        end
        epc_pkg::OFS_TL_CONTROL: begin
          next_rdata[epc_pkg::DST_DCCS_LSB +: epc_pkg::W_DCCS] =
            dataChangeCountSelect[di];
        end
        epc_pkg::OFS_PHY_TWO: begin
          if (di != 2'h0) begin
            next_rdata[epc_pkg::DST_PHY2_LSB +: epc_pkg::W_PHY2] =
              phyParamTwo[di[0] ? 1'b0 : 1'b1];
          end
        end
        epc_pkg::OFS_PHY_THREE: begin
          if (di != 2'h0) begin
            next_rdata[epc_pkg::DST_PHY3_LSB +: epc_pkg::W_PHY3] =
              phyParamThree[di[0] ? 1'b0 : 1'b1];
          end
        end
        epc_pkg::OFS_DEEMPH: begin
          if (di != 2'h0) begin
            next_rdata[epc_pkg::DST_DEEMPH] =
              deemphasisSelect[di[0] ? 1'b0 : 1'b1];
          end
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Access answer one cycle after the request is taken
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfgAck <= 1'b0;
      cfgRdata <= 32'h0000_0000;
    end else begin
      cfgAck <= cfgTake;
      if (cfgTake && !cfgWrite) begin
        cfgRdata <= next_rdata;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb_epc_port_config_loader.sv
// Self-checking bench for the configuration field loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    checkCount++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("BAD %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module tb_epc_port_config_loader;
  localparam logic [7:0][15:0] MEM = {16'h35A7, 16'hC3D2, 16'h9E6B,
    16'h7F18, 16'h28C5, 16'hB4E9, 16'h6D3C, 16'hA5F0};
  logic core_clk, rstn, present, flip, memPresent, wordValid, loadDone, busy;
  logic cfgReq, cfgWrite, cfgReady, cfgAck;
  logic [3:0] gap;
  logic [7:0] wordAddr, cfgOffset;
  logic [15:0] wordData;
  logic [2:0] cfgPort, complianceToDetect, noSoftReset, d1Support, d2Support;
  logic [31:0] cfgWdata, cfgRdata, rd;
  logic [2:0][1:0] dataChangeCountSelect, pmeSupport;
  logic [1:0][4:0] phyParamTwo;
  logic [1:0][6:0] phyParamThree;
  logic [1:0] deemphasisSelect;
  logic [2:0][2:0] auxCurrent;
  logic [2:0][7:0] pmData, pmCap;
  logic [2:0][15:0] down;
  logic [7:0][15:0] w;
  int errors, checkCount;
  epc_port_config_loader dut (.core_clk(core_clk), .rstn(rstn),
    .memPresent(memPresent), .wordValid(wordValid), .wordAddr(wordAddr),
    .wordData(wordData), .loadDone(loadDone), .cfgReq(cfgReq),
    .cfgWrite(cfgWrite), .cfgPort(cfgPort), .cfgOffset(cfgOffset),
    .cfgWdata(cfgWdata), .cfgReady(cfgReady), .cfgAck(cfgAck),
    .cfgRdata(cfgRdata), .complianceToDetect(complianceToDetect),
    .dataChangeCountSelect(dataChangeCountSelect), .phyParamTwo(phyParamTwo),
    .phyParamThree(phyParamThree), .deemphasisSelect(deemphasisSelect),
    .noSoftReset(noSoftReset), .auxCurrent(auxCurrent), .d1Support(d1Support),
    .d2Support(d2Support), .pmeSupport(pmeSupport), .pmData(pmData));
  epc_mem_model #(.MEM(MEM)) mem (.core_clk(core_clk), .rstn(rstn),
    .present(present), .flip(flip), .gap(gap), .memPresent(memPresent),
    .wordValid(wordValid), .wordAddr(wordAddr), .wordData(wordData),
    .loadDone(loadDone), .busy(busy));
  // Field outputs regrouped in memory word layout
  assign down[0] = {dataChangeCountSelect[0], complianceToDetect[0], 13'h0000};
  assign down[1] = {dataChangeCountSelect[1], complianceToDetect[1],
    deemphasisSelect[0], phyParamThree[0], phyParamTwo[0]};
  assign down[2] = {dataChangeCountSelect[2], complianceToDetect[2],
    deemphasisSelect[1], phyParamThree[1], phyParamTwo[1]};
  for (genvar i = 0; i < 3; i++) begin
    assign pmCap[i] = {pmeSupport[i], d2Support[i], d1Support[i],
      auxCurrent[i], noSoftReset[i]};
  end
  // Clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Expected register dword for a port and offset
  function automatic logic [31:0] reg_exp(input int p, input logic [7:0] o);
    logic [15:0] d;
    reg_exp = 32'h0000_0000;
    d = (p < 3) ? w[3 + 2 * p] : w[p - 3];
    if (p < 3 && o == 8'h40) reg_exp[29:22] = {d[7:6], 1'b0, d[5:1]};
    if (p < 3 && o == 8'h44) reg_exp[3] = d[0];
    if (p < 2 && o == 8'h44) reg_exp[31:24] = w[4 + 2 * p][15:8];
    if (p > 2 && o == 8'h78) reg_exp[11] = d[13];
    if (p > 2 && o == 8'h8C) reg_exp[9:8] = d[15:14];
    if (p > 3 && o == 8'h7C) reg_exp[12:8] = d[4:0];
    if (p > 3 && o == 8'h90) reg_exp[6:0] = d[11:5];
    if (p > 3 && o == 8'hF0) reg_exp[6] = d[12];
  endfunction
  // Prints the counts and the verdict, then stops
  task automatic results;
    $display("checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One configuration access; read data lands in rd
  task automatic cfg(input logic wr, input logic [2:0] p,
    input logic [7:0] o, input logic [31:0] d);
    @(negedge core_clk);
    cfgReq = 1'b1;
    cfgWrite = wr;
    cfgPort = p;
    cfgOffset = o;
    cfgWdata = d;
    @(negedge core_clk);
    `CHK(cfgAck, 1'b1)
    rd = cfgRdata;
    cfgReq = 1'b0;
    cfgWdata = ~d;
  endtask
  // Reset with chosen memory contents, then wait for loading to end
  task automatic start(input logic p, input logic f, input logic [3:0] g);
    int n;
    present = p;
    flip = f;
    gap = g;
    w = p ? (f ? ~MEM : MEM) : '0;
    rstn = 1'b0;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    if (p) begin
      @(negedge core_clk);
      cfgReq = 1'b1;
      @(negedge core_clk);
      `CHK(cfgAck, 1'b0)
      cfgReq = 1'b0;
    end
    n = 0;
    while (cfgReady !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 300) begin
      errors++;
      results();
    end
    `CHK(busy, 1'b0)
  endtask
  // Compares field outputs and every register view with the words
  task automatic verify;
    logic [7:0] ofs [8] = '{8'h40, 8'h44, 8'h78, 8'h7C, 8'h8C, 8'h90,
      8'hF0, 8'h00};
    `CHK(down[0][15:13], w[0][15:13])
    `CHK(down[1], w[1])
    `CHK(down[2], w[2])
    for (int p = 0; p < 3; p++) begin
      `CHK(pmCap[p], w[3 + 2 * p][7:0])
    end
    `CHK(pmData, {8'h00, w[6][15:8], w[4][15:8]})
    for (int p = 0; p < 6; p++) begin
      for (int k = 0; k < 8; k++) begin
        cfg(1'b0, 3'(p), ofs[k], 32'h0000_0000);
        `CHK(rd, reg_exp(p, ofs[k]))
      end
    end
  endtask
  // Main sequence
  initial begin
    errors = 0;
    checkCount = 0;
    rstn = 1'b0;
    present = 1'b0;
    flip = 1'b0;
    gap = 4'h0;
    cfgReq = 1'b0;
    cfgWrite = 1'b0;
    cfgPort = 3'h4;
    cfgOffset = 8'h7C;
    cfgWdata = 32'h0000_0000;
    start(1'b1, 1'b0, 4'h0);
    verify();
    $display("test back-to-back load done");
    cfg(1'b1, 3'h0, 8'h40, 32'hFFFF_FFFF);
    cfg(1'b1, 3'h1, 8'h44, 32'hFFFF_FFFF);
    cfg(1'b1, 3'h5, 8'h00, 32'hFFFF_FFFF);
    cfg(1'b1, 3'h3, 8'h78, ~reg_exp(3, 8'h78));
    w[0][13] = ~w[0][13];
    cfg(1'b1, 3'h4, 8'h7C, 32'h0000_1500);
    w[1][4:0] = 5'h15;
    cfg(1'b1, 3'h5, 8'h90, 32'h0000_002A);
    w[2][11:5] = 7'h2A;
    cfg(1'b1, 3'h3, 8'h8C, 32'h0000_0100);
    w[0][15:14] = 2'h1;
    cfg(1'b1, 3'h5, 8'hF0, ~reg_exp(5, 8'hF0));
    w[2][12] = ~w[2][12];
    verify();
    $display("test software writes done");
    start(1'b1, 1'b1, 4'h3);
    verify();
    $display("test slow inverted load done");
    start(1'b0, 1'b0, 4'h0);
    verify();
    $display("test absent memory done");
    results();
  end
endmodule
`default_nettype wire
